// *** core/bridge_bus_io_secondary_regs.v ***
// bridge_bus_io_secondary_regs.v: bus numbers, latency limit, I/O window
// and secondary status of a bridge configuration header.
// assumes: byte-wide config access decoded upstream; all inputs but sys_rst sync to clk.
`default_nettype none
`include "bridge_cfg_defs.vh"

// Function
// (RULE1) primary, secondary, subordinate numbers steer config forwarding; code decodes only secondary and subordinate, primary is stored only
// (RULE2) cycle for secondary bus number is issued as type 0
// (RULE3) cycle for bus above secondary within subordinate passes as type 1
// (RULE4) subordinate bus number: 8-bit read/write, resets to zero
// (RULE5) latency counter starts at zero on own frame, counts each clock
// (RULE6) after expiry, end own transaction once internal grant is withdrawn
// (RULE7) internal grant withdrawn whenever another master requests
// (RULE8) I/O base and limit low nibbles read 0001b; upper nibbles writable
// (RULE9) base nibble gives bits 15:12 of bottom; bits 11:0 zero
// (RULE10) limit nibble gives bits 15:12 of top; bits 11:0 ones
// (RULE11) bottom bits 31:16 come from base upper-half register
// (RULE12) top bits 31:16 come from limit upper-half register
// (RULE13) status flags clear on write one; zero leaves them
// (RULE14) bit 15 set on secondary parity error
// (RULE15) bit 14 set on received system error; never drive it
// (RULE16) bit 13 set when own cycle ends in master abort
// (RULE17) bit 12 set when own cycle gets target abort
// (RULE18) bit 11 set when bridge signals target abort
// (RULE19) bits 10:9 read fixed 01b
// (RULE20) bit 8 set on error-line while master with response enabled
// (RULE21) bits 7 to 0 read zero
// (RULE22) I/O address in window if between base and limit inclusive
// (RULE23) type 1 forwarded only for bus from secondary to subordinate
module bridge_bus_io_secondary_regs #(
    parameter LAT_WIDTH = 8
) (
    input wire clk, // clock
    input wire sys_rst, // async reset, high
    input wire cfg_wr, // config write strobe, one byte
    input wire cfg_rd, // config read strobe, one byte
    input wire [7:0] cfg_addr, // config byte offset
    input wire [7:0] cfg_wdata, // write byte
    output reg [7:0] cfg_rdata, // read byte, registered
    input wire fwd_valid, // type 1 config cycle seen upstream
    input wire [7:0] fwd_bus, // its target bus number
    output reg fwd_hit, // cycle passes the bridge
    output reg fwd_type0, // issue downstream as type 0
    output reg fwd_type1, // pass downstream as type 1
    input wire [31:0] io_addr, // I/O address under test
    output reg io_in_window, // address inside forwarding window
    output reg [31:0] io_bottom_addr, // assembled window bottom
    output reg [31:0] io_top_addr, // assembled window top
    input wire frame_start, // bridge asserts secondary frame
    input wire xfer_done, // bridge secondary transaction over
    input wire other_req, // another secondary master requests
    output wire grant_internal, // internal secondary grant
    output wire must_stop, // end own secondary transaction now
    input wire parity_err, // parity error on secondary side
    input wire serr_seen, // secondary system error line asserted
    output wire serr_drive, // never driven: stays 0
    input wire master_abort, // own cycle master-aborted
    input wire target_abort_rcvd, // own cycle target-aborted
    input wire target_abort_sig, // bridge signaled target abort
    input wire perr_seen, // secondary data parity line asserted
    input wire is_master, // bridge is master this cycle
    input wire perr_resp_en, // parity error response enable
    output wire [15:0] err_flags // secondary status view
);
    // ************************************************************
    // register storage
    // ************************************************************
    reg [7:0] upstream_bus_num_reg;
    reg [7:0] downstream_bus_num_reg;
    reg [7:0] highest_bus_num_reg;
    reg [7:0] latency_limit_reg;
    reg [3:0] io_bottom_nib_reg;
    reg [3:0] io_top_nib_reg;
    reg [15:0] io_bottom_upper_reg;
    reg [15:0] io_top_upper_reg;
    reg [5:0] flag_reg; // bits 15..11 and 8
    reg [5:0] flag_set;
    reg [5:0] flag_clr;
    reg [15:0] err_view;
    reg [7:0] rdata_next;
    wire [7:0] io_bottom_byte;
    wire [7:0] io_top_byte;
    wire [31:0] bottom_next;
    wire [31:0] top_next;

    assign io_bottom_byte = {io_bottom_nib_reg, `IO_DECODE_32}; // RULE8
    assign io_top_byte = {io_top_nib_reg, `IO_DECODE_32}; // RULE8
    assign serr_drive = 1'b0; // RULE15

    // ************************************************************
    // writes
    // ************************************************************
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            upstream_bus_num_reg <= `RST_BUS_NUM;
            downstream_bus_num_reg <= `RST_BUS_NUM;
            highest_bus_num_reg <= `RST_BUS_NUM; // RULE4
            latency_limit_reg <= `RST_LATENCY;
            io_bottom_nib_reg <= `RST_IO_NIBBLE;
            io_top_nib_reg <= `RST_IO_NIBBLE;
            io_bottom_upper_reg <= `RST_IO_UPPER;
            io_top_upper_reg <= `RST_IO_UPPER;
        end else if (cfg_wr) begin
            case (cfg_addr)
                `OFS_UPSTREAM_BUS: upstream_bus_num_reg <= cfg_wdata;
                `OFS_DOWNSTREAM_BUS: downstream_bus_num_reg <= cfg_wdata;
                `OFS_HIGHEST_BUS: highest_bus_num_reg <= cfg_wdata; // RULE4
                `OFS_LATENCY_LIMIT: latency_limit_reg <= cfg_wdata;
                `OFS_IO_BOTTOM: io_bottom_nib_reg <= cfg_wdata[7:4]; // RULE8
                `OFS_IO_TOP: io_top_nib_reg <= cfg_wdata[7:4]; // RULE8
                `OFS_IO_BOTTOM_UPPER_LO:
                    io_bottom_upper_reg[7:0] <= cfg_wdata;
                `OFS_IO_BOTTOM_UPPER_HI:
                    io_bottom_upper_reg[15:8] <= cfg_wdata;
                `OFS_IO_TOP_UPPER_LO: io_top_upper_reg[7:0] <= cfg_wdata;
                `OFS_IO_TOP_UPPER_HI: io_top_upper_reg[15:8] <= cfg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // secondary status flags
    // ************************************************************
    always @* begin
        flag_set = {parity_err, // RULE14
                    serr_seen, // RULE15
                    master_abort, // RULE16
                    target_abort_rcvd, // RULE17
                    target_abort_sig, // RULE18
                    perr_seen && is_master && perr_resp_en}; // RULE20
        flag_clr = 6'h00;
        // bit 8 lives in the high byte, so its clear rides on bit 0 there
        if (cfg_wr && cfg_addr == `OFS_ERR_FLAGS_HI) begin
            flag_clr[5:1] = cfg_wdata[7:3]; // RULE13
            flag_clr[0] = cfg_wdata[0]; // RULE13
        end
    end

    // a new event in the clearing cycle survives: set beats clear
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            flag_reg <= 6'h00;
        else
            flag_reg <= (flag_reg & ~flag_clr) | flag_set; // RULE13
    end

    always @* begin
        err_view = `ERR_FIXED_BITS; // RULE19 RULE21
        err_view[`ERR_PARITY_DET] = flag_reg[5];
        err_view[`ERR_SERR_RCVD] = flag_reg[4];
        err_view[`ERR_MABORT_RCVD] = flag_reg[3];
        err_view[`ERR_TABORT_RCVD] = flag_reg[2];
        err_view[`ERR_TABORT_SIG] = flag_reg[1];
        err_view[`ERR_DATA_PARITY] = flag_reg[0];
    end
    assign err_flags = err_view;

    // ************************************************************
    // reads
    // ************************************************************
    always @* begin
        case (cfg_addr)
            `OFS_UPSTREAM_BUS: rdata_next = upstream_bus_num_reg;
            `OFS_DOWNSTREAM_BUS: rdata_next = downstream_bus_num_reg;
            `OFS_HIGHEST_BUS: rdata_next = highest_bus_num_reg;
            `OFS_LATENCY_LIMIT: rdata_next = latency_limit_reg;
            `OFS_IO_BOTTOM: rdata_next = io_bottom_byte;
            `OFS_IO_TOP: rdata_next = io_top_byte;
            `OFS_ERR_FLAGS_LO: rdata_next = err_view[7:0];
            `OFS_ERR_FLAGS_HI: rdata_next = err_view[15:8];
            `OFS_IO_BOTTOM_UPPER_LO: rdata_next = io_bottom_upper_reg[7:0];
            `OFS_IO_BOTTOM_UPPER_HI: rdata_next = io_bottom_upper_reg[15:8];
            `OFS_IO_TOP_UPPER_LO: rdata_next = io_top_upper_reg[7:0];
            `OFS_IO_TOP_UPPER_HI: rdata_next = io_top_upper_reg[15:8];
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            cfg_rdata <= 8'h00;
        else if (cfg_rd)
            cfg_rdata <= rdata_next;
    end

    // ************************************************************
    // forwarding decode and I/O window
    // ************************************************************
    assign bottom_next = {io_bottom_upper_reg, io_bottom_nib_reg,
                          `IO_LOW_BOTTOM}; // RULE9 RULE11
    assign top_next = {io_top_upper_reg, io_top_nib_reg,
                       `IO_LOW_TOP}; // RULE10 RULE12

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fwd_hit <= 1'b0;
            fwd_type0 <= 1'b0;
            fwd_type1 <= 1'b0;
            io_in_window <= 1'b0;
            io_bottom_addr <= 32'h0000_0000;
            io_top_addr <= 32'h0000_0000;
        end else begin
            // bus range check uses secondary and subordinate numbers
            fwd_hit <= fwd_valid && fwd_bus >= downstream_bus_num_reg
                       && fwd_bus <= highest_bus_num_reg; // RULE1 RULE23
            fwd_type0 <= fwd_valid
                         && fwd_bus == downstream_bus_num_reg; // RULE2
            fwd_type1 <= fwd_valid && fwd_bus > downstream_bus_num_reg
                         && fwd_bus <= highest_bus_num_reg; // RULE3
            io_bottom_addr <= bottom_next;
            io_top_addr <= top_next;
            io_in_window <= io_addr >= bottom_next
                            && io_addr <= top_next; // RULE22
        end
    end

    // ************************************************************
    // secondary latency
    // ************************************************************
    latency_guard #(
        .WIDTH(LAT_WIDTH)
    ) u_latency (
        .clk(clk),
        .sys_rst(sys_rst),
        .limit(latency_limit_reg[LAT_WIDTH-1:0]),
        .frame_start(frame_start),
        .xfer_done(xfer_done),
        .other_req(other_req),
        .timer_expired(),
        .grant_internal(grant_internal), // RULE7
        .must_stop(must_stop) // RULE6
    );
endmodule // bridge_bus_io_secondary_regs

`default_nettype wire

// *** core/bridge_cfg_defs.vh ***
// bridge_cfg_defs.vh: offsets, field positions, reset values of the
// bridge bus-number, I/O window and secondary status registers.
// assumes: included by bare name from the core files.
`ifndef BRIDGE_CFG_DEFS_VH
`define BRIDGE_CFG_DEFS_VH

`define OFS_UPSTREAM_BUS 8'h18
`define OFS_DOWNSTREAM_BUS 8'h19
`define OFS_HIGHEST_BUS 8'h1A
`define OFS_LATENCY_LIMIT 8'h1B
`define OFS_IO_BOTTOM 8'h1C
`define OFS_IO_TOP 8'h1D
`define OFS_ERR_FLAGS_LO 8'h1E
`define OFS_ERR_FLAGS_HI 8'h1F
`define OFS_IO_BOTTOM_UPPER_LO 8'h30
`define OFS_IO_BOTTOM_UPPER_HI 8'h31
`define OFS_IO_TOP_UPPER_LO 8'h32
`define OFS_IO_TOP_UPPER_HI 8'h33

`define RST_BUS_NUM 8'h00
`define RST_LATENCY 8'h00
`define RST_IO_NIBBLE 4'h0
`define IO_DECODE_32 4'h1
`define RST_IO_UPPER 16'h0000
`define ERR_FIXED_BITS 16'h0200

`define ERR_PARITY_DET 15
`define ERR_SERR_RCVD 14
`define ERR_MABORT_RCVD 13
`define ERR_TABORT_RCVD 12
`define ERR_TABORT_SIG 11
`define ERR_DATA_PARITY 8

`define IO_LOW_BOTTOM 12'h000
`define IO_LOW_TOP 12'hFFF

`endif

// *** core/latency_guard.v ***
// latency_guard.v: secondary master latency counter and internal grant.
// assumes: frame_start pulses on the cycle the bridge asserts its frame.
`default_nettype none

module latency_guard #(
    parameter WIDTH = 8
) (
    input wire clk, // clock
    input wire sys_rst, // async reset, high
    input wire [WIDTH-1:0] limit, // programmed latency limit
    input wire frame_start, // bridge starts as initiator
    input wire xfer_done, // bridge transaction ended
    input wire other_req, // another secondary master requests
    output reg timer_expired, // counter reached limit
    output wire grant_internal, // internal secondary grant
    output wire must_stop // bridge must end its transaction
);
    reg active_reg;
    reg [WIDTH-1:0] count_reg;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_reg <= 1'b0;
            count_reg <= {WIDTH{1'b0}};
            timer_expired <= 1'b0;
        end else if (frame_start) begin
            active_reg <= 1'b1;
            count_reg <= {WIDTH{1'b0}}; // RULE5
            timer_expired <= 1'b0;
        end else if (xfer_done) begin
            active_reg <= 1'b0;
            timer_expired <= 1'b0;
        end else if (active_reg) begin
            if (count_reg != limit)
                count_reg <= count_reg + 1'b1; // RULE5
            else
                timer_expired <= 1'b1;
        end
    end

    // grant drops as soon as another master asks
    assign grant_internal = !other_req; // RULE7
    assign must_stop = active_reg && timer_expired && !grant_internal; // RULE6
endmodule // latency_guard

`default_nettype wire

// *** bench/bridge_regs_chk.sv ***
// checker: timing relations at the register block's ports.
// assumes: bound to the block, clk rising edge, sys_rst async high.
`default_nettype none
module bridge_regs_chk #(
    parameter LAT_WIDTH = 8
) (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic fwd_hit, // forward
    input wire logic fwd_type0, // type 0
    input wire logic fwd_type1, // type 1
    input wire logic [31:0] io_bottom_addr, // bottom
    input wire logic [31:0] io_top_addr, // top
    input wire logic other_req, // request
    input wire logic grant_internal, // grant
    input wire logic must_stop, // stop
    input wire logic parity_err, // parity
    input wire logic serr_seen, // system error
    input wire logic serr_drive, // error drive
    input wire logic master_abort, // m abort
    input wire logic target_abort_rcvd, // t abort in
    input wire logic target_abort_sig, // t abort out
    input wire logic perr_seen, // data parity
    input wire logic is_master, // master
    input wire logic perr_resp_en, // response
    input wire logic [15:0] err_flags // status
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_serr_quiet: assert property (serr_drive == 1'b0)
        else $error("error line driven");
    a_grant_req: assert property (grant_internal == !other_req)
        else $error("grant kept under request");
    a_stop_cause: assert property (must_stop |-> !grant_internal)
        else $error("stop while granted");
    // bit 8 is a sticky flag, so only 10:9 and 7:0 are fixed
    a_fixed_bits: assert property (
        err_flags[10:9] == 2'b01 && err_flags[7:0] == 8'h00)
        else $error("fixed status bits wrong");
    a_parity_set: assert property (parity_err |=> err_flags[15])
        else $error("parity flag not set");
    a_serr_set: assert property (serr_seen |=> err_flags[14])
        else $error("system error flag not set");
    a_mabort_set: assert property (master_abort |=> err_flags[13])
        else $error("master abort flag not set");
    a_tabort_rcvd: assert property (
        target_abort_rcvd |=> err_flags[12])
        else $error("target abort flag not set");
    a_tabort_sig: assert property (
        target_abort_sig |=> err_flags[11])
        else $error("signaled abort flag not set");
    a_perr_set: assert property (
        perr_seen && is_master && perr_resp_en |=> err_flags[8])
        else $error("data parity flag not set");
    a_perr_gate: assert property (
        !err_flags[8] && !(perr_seen && is_master && perr_resp_en)
        |=> !err_flags[8])
        else $error("data parity flag set without cause");
    a_type_hit: assert property (
        fwd_type0 || fwd_type1 |-> fwd_hit && (fwd_type0 != fwd_type1))
        else $error("type without single hit");
    a_io_low: assert property (
        !$past(sys_rst) |-> io_bottom_addr[11:0] == 12'h000
        && io_top_addr[11:0] == 12'hfff)
        else $error("window low bits wrong");
endmodule // bridge_regs_chk
`default_nettype wire

// *** bench/sec_bus_agent.sv ***
// secondary-bus agents: raise event lines and a bus request on command.
// assumes: commands from the bench on the rising edge, async high reset.
`default_nettype none
module sec_bus_agent (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [5:0] ev_mask, // events to raise
    input wire logic ev_fire, // raise them next cycle
    input wire logic want_bus, // another master wants the bus
    output var logic [5:0] ev_lines, // perr,tas,tar,ma,serr,par
    output var logic other_req // request level
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ev_lines <= 6'h00;
            other_req <= 1'b0;
        end else begin
            // single-cycle events, released at once so none is seen twice
            ev_lines <= ev_fire ? ev_mask : 6'h00;
            other_req <= want_bus;
        end
    end
endmodule // sec_bus_agent
`default_nettype wire

// *** bench/bridge_bus_io_secondary_regs_tb_top.sv ***
// bench: config registers, forward decode, I/O window, stop, status.
// assumes: core files, checker and agent compiled before this file.
`default_nettype none
module bridge_bus_io_secondary_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0, fwd_valid = 0;
    logic frame_start = 0, xfer_done = 0, is_master = 0, perr_resp_en = 0;
    logic ev_fire = 0, want_bus = 0, fwd_hit, fwd_type0, fwd_type1;
    logic io_in_window, grant_internal, must_stop, serr_drive, other_req;
    logic [7:0] cfg_addr = 0, cfg_wdata = 0, fwd_bus = 0, cfg_rdata;
    logic [5:0] ev_mask = 0, ev_lines;
    logic [31:0] io_addr = 0, io_bottom_addr, io_top_addr;
    logic [15:0] err_flags, m;
    int errors = 0, checked = 0;
    int fbit [6] = '{15, 14, 13, 12, 11, 8};
    logic [7:0] bus [5] = '{8'h04, 8'h05, 8'h06, 8'h09, 8'h0a};
    logic [7:0] ra [13] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d,
        8'h1e, 8'h1f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40};
    logic [7:0] rv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
        8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] wv [13] = '{8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'ha1, 8'ha1,
        8'h00, 8'h02, 8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'h00};
    logic [31:0] ioa [4] = '{32'h1234_2fff, 32'h1234_3000, 32'h1234_5fff,
        32'h1234_6000};
    always #2 clk = ~clk;
    bridge_bus_io_secondary_regs #(.LAT_WIDTH(8)) u_dut (.clk(clk),
        .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .fwd_valid(fwd_valid), .fwd_bus(fwd_bus), .fwd_hit(fwd_hit),
        .fwd_type0(fwd_type0), .fwd_type1(fwd_type1), .io_addr(io_addr),
        .io_in_window(io_in_window), .io_bottom_addr(io_bottom_addr),
        .io_top_addr(io_top_addr), .frame_start(frame_start),
        .xfer_done(xfer_done), .other_req(other_req),
        .grant_internal(grant_internal), .must_stop(must_stop),
        .parity_err(ev_lines[0]), .serr_seen(ev_lines[1]),
        .serr_drive(serr_drive), .master_abort(ev_lines[2]),
        .target_abort_rcvd(ev_lines[3]), .target_abort_sig(ev_lines[4]),
        .perr_seen(ev_lines[5]), .is_master(is_master),
        .perr_resp_en(perr_resp_en), .err_flags(err_flags));
    sec_bus_agent u_agent (.clk(clk), .sys_rst(sys_rst), .ev_mask(ev_mask),
        .ev_fire(ev_fire), .want_bus(want_bus), .ev_lines(ev_lines),
        .other_req(other_req));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1 chk(cfg_rdata, e, $sformatf("reg %h", a));
    endtask
    task automatic ev(input logic [5:0] mk);
        @(posedge clk);
        ev_fire <= 1'b1;
        ev_mask <= mk;
        @(posedge clk);
        ev_fire <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic summarize;
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        foreach (ra[i]) wr(ra[i], 8'ha5);
        foreach (ra[i]) rd(ra[i], wv[i]);
        wr(8'h19, 8'h05);
        wr(8'h1a, 8'h09);
        foreach (bus[i]) begin
            @(posedge clk);
            fwd_valid <= 1'b1;
            fwd_bus <= bus[i];
            @(posedge clk);
            fwd_valid <= 1'b0;
            #1 chk(fwd_hit, bus[i] >= 5 && bus[i] <= 9, "hit");
            chk(fwd_type0, bus[i] == 5, "type0");
            chk(fwd_type1, bus[i] > 5 && bus[i] <= 9, "type1");
        end
        wr(8'h1c, 8'h30);
        wr(8'h1d, 8'h50);
        wr(8'h30, 8'h34);
        wr(8'h31, 8'h12);
        wr(8'h32, 8'h34);
        wr(8'h33, 8'h12);
        repeat (2) @(posedge clk);
        #1 chk(io_bottom_addr, 32'h1234_3000, "bottom");
        chk(io_top_addr, 32'h1234_5fff, "top");
        foreach (ioa[i]) begin
            @(posedge clk);
            io_addr <= ioa[i];
            @(posedge clk);
            #1 chk(io_in_window, i == 1 || i == 2, "window");
        end
        ev(6'h20);
        rd(8'h1f, 8'h02);
        @(posedge clk);
        is_master <= 1'b1;
        perr_resp_en <= 1'b1;
        foreach (fbit[i]) begin
            m = 16'h0200 | (16'h0001 << fbit[i]);
            ev(6'h01 << i);
            wr(8'h1f, 8'h00);
            rd(8'h1f, m[15:8]);
            wr(8'h1f, m[15:8]);
            rd(8'h1f, 8'h02);
        end
        // short limit keeps the exact expiry cycle easy to predict
        wr(8'h1b, 8'h03);
        @(posedge clk);
        frame_start <= 1'b1;
        want_bus <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(must_stop, 1'b0, "early stop");
        @(posedge clk);
        #1 chk(must_stop, 1'b1, "stop");
        @(posedge clk);
        want_bus <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(must_stop, 1'b0, "grant held");
        chk(grant_internal, 1'b1, "grant");
        @(posedge clk);
        xfer_done <= 1'b1;
        want_bus <= 1'b1;
        @(posedge clk);
        xfer_done <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(must_stop, 1'b0, "after end");
        summarize();
    end
endmodule // bridge_bus_io_secondary_regs_tb_top
bind bridge_bus_io_secondary_regs bridge_regs_chk #(.LAT_WIDTH(LAT_WIDTH))
    u_chk (.clk(clk), .sys_rst(sys_rst), .fwd_hit(fwd_hit),
    .fwd_type0(fwd_type0), .fwd_type1(fwd_type1),
    .io_bottom_addr(io_bottom_addr), .io_top_addr(io_top_addr),
    .other_req(other_req), .grant_internal(grant_internal),
    .must_stop(must_stop), .parity_err(parity_err), .serr_seen(serr_seen),
    .serr_drive(serr_drive), .master_abort(master_abort),
    .target_abort_rcvd(target_abort_rcvd),
    .target_abort_sig(target_abort_sig), .perr_seen(perr_seen),
    .is_master(is_master), .perr_resp_en(perr_resp_en),
    .err_flags(err_flags));
`default_nettype wire
